// ===== logic/arrc_pkg.sv
// Package: register map, field positions and timing constants
package arrc_pkg;

  // ****************************************************
  // Register map
  // ****************************************************
  localparam int ADDR_W = 12;                     // APB address width
  localparam logic [7:0] IDX_CMP1  = 8'h9a;       // Comparator 1 ctrl index
  localparam logic [7:0] IDX_CMP2  = 8'h9b;       // Comparator 2 ctrl index
  localparam logic [7:0] IDX_MODE  = 8'hb1;       // Converter mode index
  localparam logic [7:0] IDX_RESH  = 8'hb2;       // Result high byte index
  localparam logic [7:0] IDX_CLKR  = 8'hb3;       // Clock/resolution index
  localparam logic [7:0] IDX_IRQ   = 8'hb4;       // Interrupt ctrl index
  // Byte address is four times the index
  localparam logic [ADDR_W-1:0] ADDR_CMP1 = {2'h0, IDX_CMP1, 2'h0};
  localparam logic [ADDR_W-1:0] ADDR_CMP2 = {2'h0, IDX_CMP2, 2'h0};
  localparam logic [ADDR_W-1:0] ADDR_MODE = {2'h0, IDX_MODE, 2'h0};
  localparam logic [ADDR_W-1:0] ADDR_RESH = {2'h0, IDX_RESH, 2'h0};
  localparam logic [ADDR_W-1:0] ADDR_CLKR = {2'h0, IDX_CLKR, 2'h0};
  localparam logic [ADDR_W-1:0] ADDR_IRQ  = {2'h0, IDX_IRQ, 2'h0};

  // ****************************************************
  // Field positions
  // ****************************************************
  localparam int MODE_EN    = 7;  // converter_enable
  localparam int MODE_START = 6;  // conversion_start
  localparam int MODE_EOC   = 5;  // End of conversion
  localparam int MODE_GCH   = 4;  // global_channel_enable
  localparam int MODE_REF   = 3;  // converter_reference_select
  localparam int CLK_INTREF = 7;  // internal_reference_enable
  localparam int CLK_CKS1   = 6;  // Clock select high bit
  localparam int CLK_LEN    = 5;  // resolution_select
  localparam int CLK_CKS0   = 4;  // Clock select low bit
  localparam int CMP1_REF   = 2;  // comparator1_reference_select
  localparam int CMP2_REF   = 3;  // comparator2_reference_select
  localparam int IRQ_EN     = 0;  // converter_irq_enable
  localparam int IRQ_FLAG   = 1;  // converter_irq_flag

  // ****************************************************
  // Reset values and interrupt vector
  // ****************************************************
  localparam logic [7:0] MODE_RST = 8'h00;
  localparam logic [3:0] CLKR_RST = 4'h0;
  localparam logic [2:0] CMP1_RST = 3'h0;
  localparam logic [5:0] CMP2_RST = 6'h00;
  localparam logic [7:0] IRQ_VECTOR = 8'h08;      // Processor vector

  // ****************************************************
  // Conversion timing
  // ****************************************************
  typedef enum logic [1:0] {
    CKS_DIV16 = 2'b00,
    CKS_DIV8  = 2'b01,
    CKS_DIV1  = 2'b10,
    CKS_DIV2  = 2'b11
  } arrc_cks_e;
  localparam logic [4:0] DIV_16 = 5'h10;
  localparam logic [4:0] DIV_8  = 5'h08;
  localparam logic [4:0] DIV_2  = 5'h02;
  localparam logic [4:0] DIV_1  = 5'h01;
  localparam int CONV_QTR = 4;                    // Converter clock / 4
  localparam int PER_12   = 16;                   // Periods, 12-bit
  localparam int PER_8    = 12;                   // Periods, 8-bit
  localparam logic [6:0] TICKS_12 = 7'(PER_12 * CONV_QTR);
  localparam logic [6:0] TICKS_8  = 7'(PER_8 * CONV_QTR);

  typedef enum logic {
    SEQ_IDLE = 1'b0,
    SEQ_RUN  = 1'b1
  } arrc_seq_state_e;

endpackage

// ===== logic/arrc_seq_if.sv
// Interface between register block and conversion sequencer
`timescale 1ns/10ps
interface arrc_seq_if;
  import arrc_pkg::*;
  logic      go;     // Start pulse
  logic      abort;  // Stop a running conversion
  logic      len12;  // Twelve-bit resolution
  arrc_cks_e cks;    // Converter clock select
  logic      busy;   // Conversion running
  logic      done;   // One-cycle completion pulse
  modport ctrl (output go, abort, len12, cks, input busy, done);
  modport seq  (input go, abort, len12, cks, output busy, done);
endinterface

// ===== logic/arrc_conv_seq.sv
// Conversion sequencer: times one conversion from start to done
`timescale 1ns/10ps
module arrc_conv_seq (
  input wire logic clk_sys,
  input wire logic sys_rst,
  arrc_seq_if.seq  sq
);
  import arrc_pkg::*;

  // ****************************************************
  // Decode
  // ****************************************************
  arrc_seq_state_e state_q;  // Idle or running
  logic [4:0]  div_q;        // Divider latched at start
  logic [3:0]  pre_q;        // Prescaler down counter
  logic [6:0]  ticks_q;      // Remaining quarter ticks
  logic        done_q;       // Completion pulse
  logic [10:0] elapsed_q;    // Cycles since start
  logic [10:0] expect_q;     // Expected conversion length
  logic [4:0]  div_w;
  logic [6:0]  total_w;
  logic        tick_w;
  // Clock divider per select code, see R23
  assign div_w = (sq.cks == CKS_DIV16) ? DIV_16 :
                 (sq.cks == CKS_DIV8)  ? DIV_8  :
                 (sq.cks == CKS_DIV1)  ? DIV_1  : DIV_2;
  // Quarter-clock ticks per conversion, see R22
  assign total_w = sq.len12 ? TICKS_12 : TICKS_8;
  assign tick_w  = (pre_q == 4'h0);
  assign sq.busy = (state_q == SEQ_RUN);
  assign sq.done = done_q;

  // ****************************************************
  // Sequencer
  // ****************************************************
  // Divider is latched so a late clock change cannot stretch a run
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      state_q <= SEQ_IDLE;
      div_q   <= DIV_1;
      pre_q   <= 4'h0;
      ticks_q <= 7'h00;
      done_q  <= 1'b0;
    end
    else
    begin
      done_q <= 1'b0;
      case (state_q)
        SEQ_IDLE:
          if (sq.go)
          begin
            state_q <= SEQ_RUN;
            div_q   <= div_w;
            pre_q   <= 4'(div_w - 5'h01);
            ticks_q <= total_w - 7'h01;
          end
        SEQ_RUN:
          if (sq.abort)
            state_q <= SEQ_IDLE;  // Stopped by software
          else if (tick_w)
          begin
            pre_q <= 4'(div_q - 5'h01);
            if (ticks_q == 7'h00)
            begin
              state_q <= SEQ_IDLE;
              done_q  <= 1'b1;    // see R22
            end
            else
              ticks_q <= ticks_q - 7'h01;
          end
          else
            pre_q <= pre_q - 4'h1;
        default: state_q <= SEQ_IDLE;
      endcase
    end
  end

  // Helper counters read only by the checks below
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst | sq.go)
      elapsed_q <= 11'h000;
    else
      elapsed_q <= elapsed_q + 11'h001;
    // Widened first: a 1024-cycle run needs all eleven bits
    if (sq.go)
      expect_q <= 11'(div_w) * 11'(total_w);
  end

  a_conv_length: assert property (@(posedge clk_sys) disable iff (sys_rst) // see R22 R23
    done_q |-> elapsed_q == expect_q)
    else $error("conversion length wrong");
  a_abort_idle: assert property (@(posedge clk_sys) disable iff (sys_rst)
    sq.busy && sq.abort |=> !sq.busy && !done_q)
    else $error("abort did not stop conversion");

endmodule

// ===== logic/arrc_top.sv
// Converter result, control and reference select registers on APB
//
// Behaviour
// R1 - Result held as twelve bits over two registers
// R2 - Result registers ignore writes
// R3 - Eight-bit result sits in high byte
// R4 - Twelve-bit result spans high byte and nibble
// R5 - Result coded as straight binary
// R6 - Software trims twelve-bit result for fewer bits
// R7 - Software waits warm-up after enabling converter
// R8 - Software disables converter in low power modes
// R9 - Start bit clears itself at completion
// R10 - End flag low from start until done
// R11 - End flag set when conversion finishes
// R12 - End flag writable for software clearing
// R13 - Completion sets interrupt flag, vector eight
// R14 - Software configures mode, clock, reference, pins
// R15 - Software selects channel, irq, then starts
// R16 - Software masks low nibble to assemble result
// R17 - Clock register bit 7 enables internal reference
// R18 - Software enables reference before selecting it
// R19 - Comparator 1 reference select at bit 2
// R20 - Comparator 2 reference select at bit 3
// R21 - Mode register bit selects converter reference
// R22 - Conversion lasts 16 or 12 quarter periods
// R23 - Clock select codes divide by 16,8,1,2
// R24 - Resolution bit picks eight or twelve bits
// R25 - Channel code picks input or op-amp
// R26 - Result stable until next completion
//
// Our own choice: the APB interface to the registers.
`timescale 1ns/10ps
module arrc_top (
  input  wire logic                        clk_sys,
  input  wire logic                        sys_rst,
  input  wire logic                        psel,
  input  wire logic                        penable,
  input  wire logic                        pwrite,
  input  wire logic [arrc_pkg::ADDR_W-1:0] paddr,
  input  wire logic [31:0]                 pwdata,
  output logic                             pready,
  output logic      [31:0]                 prdata,
  output logic                             pslverr,
  input  wire logic [11:0]                 conv_data,
  output logic                             conv_enable,
  output logic                             conv_start,
  output logic                             conv_busy,
  output logic                             conv_len12,
  output logic                             conv_ref_sel,
  output logic      [2:0]                  channel_sel,
  output logic                             channel_enable,
  output logic                             int_ref_enable,
  output logic      [2:0]                  cmp1_ctrl,
  output logic                             cmp1_ref_sel,
  output logic      [5:0]                  cmp2_ctrl,
  output logic                             cmp2_ref_sel,
  output logic                             irq_req,
  output logic      [7:0]                  irq_vector
);
  import arrc_pkg::*;

  // ****************************************************
  // Declarations
  // ****************************************************
  arrc_seq_if sq ();            // Link to the sequencer

  logic        en_q;            // converter_enable
  logic        start_q;         // conversion_start
  logic        eoc_q;           // End of conversion flag
  logic        gch_q;           // global_channel_enable
  logic        ref_q;           // converter_reference_select
  logic [2:0]  chs_q;           // input_channel_select
  logic        intref_q;        // internal_reference_enable
  logic [1:0]  cks_q;           // converter_clock_select
  logic        len_q;           // resolution_select
  logic [7:0]  res_hi_q;        // result_high_byte
  logic [3:0]  res_lo_q;        // Result low nibble
  logic [2:0]  cmp1_q;          // comparator1_reference_ctrl
  logic [5:0]  cmp2_q;          // comparator2_reference_ctrl
  logic        irq_en_q;        // converter_irq_enable
  logic        irq_flag_q;      // converter_irq_flag
  logic [31:0] prdata_q;        // Registered read data

  logic        setup_w;         // APB setup phase
  logic        acc_w;           // APB access phase
  logic        wr_w;            // Write taking effect
  logic [7:0]  wd_w;            // Write byte
  logic        hit_cmp1;
  logic        hit_cmp2;
  logic        hit_mode;
  logic        hit_resh;
  logic        hit_clkr;
  logic        hit_irq;
  logic        mapped_w;        // Any register hit
  logic        wr_mode;
  logic        wr_clkr;
  logic        wr_cmp1;
  logic        wr_cmp2;
  logic        wr_irq;
  logic        start_go_w;      // Software starts a conversion
  logic [7:0]  mode_rd_w;
  logic [7:0]  clkr_rd_w;
  logic [7:0]  irq_rd_w;
  logic [7:0]  rdata_w;         // Selected read byte

  // ****************************************************
  // APB decode
  // ****************************************************
  // Zero wait states: every access completes in one cycle
  assign setup_w  = psel & ~penable;
  assign acc_w    = psel & penable;
  assign wr_w     = acc_w & pwrite;
  assign wd_w     = pwdata[7:0];
  assign hit_cmp1 = (paddr == ADDR_CMP1);
  assign hit_cmp2 = (paddr == ADDR_CMP2);
  assign hit_mode = (paddr == ADDR_MODE);
  assign hit_resh = (paddr == ADDR_RESH);
  assign hit_clkr = (paddr == ADDR_CLKR);
  assign hit_irq  = (paddr == ADDR_IRQ);
  assign mapped_w = hit_cmp1 | hit_cmp2 | hit_mode |
                    hit_resh | hit_clkr | hit_irq;
  assign wr_mode  = wr_w & hit_mode;
  assign wr_clkr  = wr_w & hit_clkr;
  assign wr_cmp1  = wr_w & hit_cmp1;
  assign wr_cmp2  = wr_w & hit_cmp2;
  assign wr_irq   = wr_w & hit_irq;
  // A write to the result byte has no decode term at all, see R2

  // Start only counts while the same write keeps the converter on
  assign start_go_w = wr_mode & wd_w[MODE_START] & wd_w[MODE_EN];

  assign pready  = 1'b1;
  assign pslverr = acc_w & ~mapped_w;  // Unmapped address
  assign prdata  = prdata_q;

  // ****************************************************
  // Read mux
  // ****************************************************
  assign mode_rd_w = {en_q, start_q, eoc_q, gch_q, ref_q, chs_q};
  assign clkr_rd_w = {intref_q, cks_q[1], len_q, cks_q[0], res_lo_q};
  assign irq_rd_w  = {6'h00, irq_flag_q, irq_en_q};
  assign rdata_w   = hit_mode ? mode_rd_w :
                     hit_clkr ? clkr_rd_w :
                     hit_resh ? res_hi_q :
                     hit_cmp1 ? {5'h00, cmp1_q} :
                     hit_cmp2 ? {2'h0, cmp2_q} :
                     hit_irq  ? irq_rd_w : 8'h00;

  // Read data captured in setup so it stands through access
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
      prdata_q <= 32'h0000_0000;
    else if (setup_w & ~pwrite)
      prdata_q <= {24'h00_0000, rdata_w};
  end

  // ****************************************************
  // Mode register
  // ****************************************************
  // Enable, channel and reference bits are plain storage
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      en_q  <= MODE_RST[MODE_EN];
      gch_q <= MODE_RST[MODE_GCH];
      ref_q <= MODE_RST[MODE_REF];    // see R21
      chs_q <= MODE_RST[2:0];
    end
    else if (wr_mode)
    begin
      en_q  <= wd_w[MODE_EN];
      gch_q <= wd_w[MODE_GCH];
      ref_q <= wd_w[MODE_REF];        // see R21
      chs_q <= wd_w[2:0];             // see R25
    end
  end

  // Start bit: set by software, dropped by hardware at the end
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
      start_q <= MODE_RST[MODE_START];
    else if (start_go_w)
      start_q <= 1'b1;
    else if (sq.done)
      start_q <= 1'b0;                // see R9
    else if (wr_mode | ~en_q)
      start_q <= 1'b0;                // Stopped or disabled
  end

  // End flag: a completion beats a software clear
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
      eoc_q <= MODE_RST[MODE_EOC];
    else if (start_go_w)
      eoc_q <= 1'b0;                  // see R10
    else if (sq.done)
      eoc_q <= 1'b1;                  // see R11
    else if (wr_mode & ~start_q)
      eoc_q <= wd_w[MODE_EOC];        // see R12
  end

  // ****************************************************
  // Clock and resolution register
  // ****************************************************
  // Low nibble is result data and is not written here
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      intref_q <= CLKR_RST[3];        // see R17
      cks_q    <= CLKR_RST[2:1];
      len_q    <= CLKR_RST[0];
    end
    else if (wr_clkr)
    begin
      intref_q <= wd_w[CLK_INTREF];   // see R17
      cks_q    <= {wd_w[CLK_CKS1], wd_w[CLK_CKS0]};  // see R23
      len_q    <= wd_w[CLK_LEN];      // see R24
    end
  end

  // ****************************************************
  // Result buffer
  // ****************************************************
  // New value lands in the same cycle as the end flag.
  // Reset clears it, which is one legal value of undefined.
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      res_hi_q <= 8'h00;
      res_lo_q <= 4'h0;
    end
    else if (sq.done)
    begin
      res_hi_q <= conv_data[11:4];    // see R1 R3 R5 R26
      // Eight-bit mode leaves the nibble at zero
      res_lo_q <= len_q ? conv_data[3:0] : 4'h0;  // see R4
    end
  end

  // ****************************************************
  // Comparator reference registers
  // ****************************************************
  // Only the low bits exist; the rest read as zero
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      cmp1_q <= CMP1_RST;
      cmp2_q <= CMP2_RST;
    end
    else
    begin
      if (wr_cmp1)
        cmp1_q <= wd_w[2:0];          // see R19
      if (wr_cmp2)
        cmp2_q <= wd_w[5:0];          // see R20
    end
  end

  // ****************************************************
  // Interrupt request
  // ****************************************************
  // Flag is set on completion; writing zero clears it
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      irq_en_q   <= 1'b0;
      irq_flag_q <= 1'b0;
    end
    else
    begin
      if (wr_irq)
        irq_en_q <= wd_w[IRQ_EN];
      if (sq.done)
        irq_flag_q <= 1'b1;           // see R13
      else if (wr_irq & ~wd_w[IRQ_FLAG])
        irq_flag_q <= 1'b0;
    end
  end

  assign irq_req    = irq_flag_q & irq_en_q;    // see R13
  assign irq_vector = IRQ_VECTOR;

  // ****************************************************
  // Sequencer and analog side
  // ****************************************************
  // A new run cannot start in the completion cycle
  assign sq.go    = start_q & en_q & ~sq.busy & ~sq.done;
  assign sq.abort = ~start_q;         // Start cleared or disabled
  assign sq.len12 = len_q;            // see R24
  assign sq.cks   = arrc_cks_e'(cks_q);

  arrc_conv_seq u_seq (
    .clk_sys (clk_sys),
    .sys_rst (sys_rst),
    .sq      (sq.seq)
  );

  assign conv_enable    = en_q;
  assign conv_start     = sq.go;
  assign conv_busy      = sq.busy;
  assign conv_len12     = len_q;
  assign conv_ref_sel   = ref_q;      // see R21
  assign channel_sel    = chs_q;      // see R25
  assign channel_enable = gch_q;
  assign int_ref_enable = intref_q;   // see R17
  assign cmp1_ctrl      = cmp1_q;
  assign cmp1_ref_sel   = cmp1_q[CMP1_REF];   // see R19
  assign cmp2_ctrl      = cmp2_q;
  assign cmp2_ref_sel   = cmp2_q[CMP2_REF];   // see R20

  // ****************************************************
  // Checks
  // ****************************************************
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);

  sequence s_bad_setup;
    setup_w && !mapped_w;
  endsequence

  sequence s_bad_access;
    acc_w && !mapped_w;
  endsequence

  a_start_clr_eoc: assert property ( // see R10
    start_go_w |=> !eoc_q && start_q)
    else $error("start did not clear end flag");

  a_busy_no_eoc: assert property ( // see R10
    start_q |-> !eoc_q)
    else $error("end flag high while started");

  a_done_eoc: assert property ( // see R9 R11
    sq.done && !start_go_w |=> eoc_q && !start_q)
    else $error("completion did not update flags");

  a_result_load: assert property ( // see R1 R3 R5
    sq.done |=> res_hi_q == $past(conv_data[11:4]))
    else $error("high byte not loaded");

  a_nibble_load: assert property ( // see R4
    sq.done && len_q |=> res_lo_q == $past(conv_data[3:0]))
    else $error("low nibble not loaded");

  a_result_hold: assert property ( // see R26 R2
    !sq.done |=> $stable(res_hi_q) && $stable(res_lo_q))
    else $error("result changed without completion");

  a_irq_flag_set: assert property ( // see R13
    sq.done ##1 irq_en_q |-> irq_req)
    else $error("completion raised no interrupt");

  a_cmp1_ref_sel: assert property ( // see R19
    wr_cmp1 |=> cmp1_ref_sel == $past(pwdata[CMP1_REF]))
    else $error("comparator 1 reference select wrong");

  a_cmp2_ref_sel: assert property ( // see R20
    wr_cmp2 |=> cmp2_ref_sel == $past(pwdata[CMP2_REF]))
    else $error("comparator 2 reference select wrong");

  a_go_busy: assert property ( // see R10
    start_go_w && !sq.busy |-> ##[1:2] sq.busy)
    else $error("conversion did not start");

  a_unmapped_err: assert property (
    s_bad_setup ##1 s_bad_access |-> pslverr && pready)
    else $error("unmapped access not refused");

endmodule

// ===== tb/arrc_top_tb.sv
// Self-checking bench for the converter control and reference register block
`timescale 1ns/10ps
module arrc_top_tb;
  import arrc_pkg::*;
  logic        clk_sys, sys_rst, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic [11:0] conv_data;
  logic        conv_enable, conv_start, conv_busy, conv_len12, conv_ref_sel;
  logic        channel_enable, int_ref_enable, cmp1_ref_sel, cmp2_ref_sel, irq_req;
  logic [2:0]  channel_sel, cmp1_ctrl;
  logic [5:0]  cmp2_ctrl;
  logic [7:0]  irq_vector;
  logic [33:0] exp_q[$];     // Pending reads: {check, error, data}
  logic [33:0] ent;          // Oldest pending read
  logic [31:0] rd_word;      // Last word read by the driver
  int          err_total, n_compared, busy_cnt, cyc, seed, n_start;

  arrc_top arrc_top_i (.clk_sys, .sys_rst, .psel, .penable, .pwrite, .paddr, .pwdata,
    .pready, .prdata, .pslverr, .conv_data, .conv_enable, .conv_start, .conv_busy,
    .conv_len12, .conv_ref_sel, .channel_sel, .channel_enable, .int_ref_enable,
    .cmp1_ctrl, .cmp1_ref_sel, .cmp2_ctrl, .cmp2_ref_sel, .irq_req, .irq_vector);

  // Free-running 100 MHz clock
  initial
  begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  // ****************************************************
  // Compare, bus and closing tasks
  // ****************************************************
  task automatic chk_bit(input string nm, input logic e, input logic g);
    n_compared++;
    if (g !== e)
    begin
      err_total++;
      $display("unexpected %s: expected %b seen %b", nm, e, g);
    end
  endtask

  task automatic chk_word(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e)
    begin
      err_total++;
      $display("unexpected %s: expected %h seen %h", nm, e, g);
    end
  endtask

  // One APB transfer; entered just after a rising edge, leaves one idle cycle
  task automatic apb(input logic wr, input logic [11:0] a, input logic [7:0] d);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= {24'h0, d};
    @(posedge clk_sys);
    penable <= 1'b1;
    // Ends once pready is high; only the bench timeout ends a wait that hangs
    do
    begin
      @(posedge clk_sys);
    end
    while (pready !== 1'b1);
    rd_word = prdata;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge clk_sys);
  endtask

  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    apb(1'b1, a, d);
  endtask

  // Polling reads pass on=0 so the monitor skips them
  task automatic rd(input logic [11:0] a, input logic [7:0] e, input logic on, input logic er);
    exp_q.push_back({on, er, 24'h0, e});
    apb(1'b0, a, 8'h00);
  endtask

  task automatic finish_test();
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // Monitor: oldest note is taken off the queue as each read completes
  always @(posedge clk_sys)
    if (psel && penable && pready && !pwrite)
    begin
      ent = exp_q.pop_front();
      if (ent[33])
      begin
        chk_word("prdata", ent[31:0], prdata);
        chk_bit("pslverr", ent[32], pslverr);
      end
    end

  // Busy length per conversion and hang guard
  always @(posedge clk_sys)
  begin
    cyc++;
    if (conv_start === 1'b1)
    begin
      busy_cnt = 0;
      n_start++;
    end
    else if (conv_busy === 1'b1)
      busy_cnt++;
    // Warm-up of 10000 plus four runs and polling stay well below this
    if (cyc == 40000)
    begin
      err_total++;
      finish_test();
    end
  end

  // ****************************************************
  // Main sequence
  // ****************************************************
  initial
  begin
    logic [7:0] r, ck, hi;
    logic [11:0] w;
    int         dv[4];
    int         n;
    dv = '{16, 8, 1, 2};
    seed = 24788;
    {sys_rst, psel, penable, pwrite} = 4'h8;
    paddr = 12'h000;
    pwdata = 32'h0;
    conv_data = 12'h000;
    repeat (10) @(posedge clk_sys);
    sys_rst <= 1'b0;
    @(posedge clk_sys);
    rd(ADDR_MODE, 8'h00, 1, 0);
    rd(ADDR_CLKR, 8'h00, 1, 0);
    rd(ADDR_CMP1, 8'h00, 1, 0);
    rd(ADDR_CMP2, 8'h00, 1, 0);
    rd(12'h004, 8'h00, 1, 1);
    // Bring-up: clear mode, reference on before anyone selects it
    wr(ADDR_MODE, 8'h00);
    wr(ADDR_CLKR, 8'h80);
    r = 8'($random(seed));
    wr(ADDR_CMP1, r);
    rd(ADDR_CMP1, {5'h0, r[2:0]}, 1, 0);
    chk_bit("cmp1_ref_sel", r[2], cmp1_ref_sel);
    chk_word("cmp1_ctrl", {29'h0, r[2:0]}, {29'h0, cmp1_ctrl});
    wr(ADDR_CMP2, ~r);
    rd(ADDR_CMP2, {2'h0, ~r[5:0]}, 1, 0);
    chk_bit("cmp2_ref_sel", ~r[3], cmp2_ref_sel);
    chk_word("cmp2_ctrl", {26'h0, ~r[5:0]}, {26'h0, cmp2_ctrl});
    wr(ADDR_MODE, 8'h9f);
    chk_bit("conv_enable", 1'b1, conv_enable);
    chk_bit("channel_enable", 1'b1, channel_enable);
    chk_bit("conv_ref_sel", 1'b1, conv_ref_sel);
    chk_word("channel_sel", 32'h7, {29'h0, channel_sel});
    // Warm-up follows enabling only: 100 us at this clock
    repeat (10000) @(posedge clk_sys);
    wr(ADDR_IRQ, 8'h01);
    // Every clock code, both resolutions
    for (int i = 0; i < 4; i++)
    begin
      ck = {1'b1, i[1], ~i[0], i[0], 4'h0};
      n = dv[i] * 4 * (i[0] ? 12 : 16);
      wr(ADDR_CLKR, ck);
      chk_bit("int_ref_enable", 1'b1, int_ref_enable);
      chk_bit("conv_len12", ~i[0], conv_len12);
      conv_data <= 12'($random(seed));
      // Channel, channel enable and reference stay set with the start
      wr(ADDR_MODE, 8'hdf);
      rd(ADDR_MODE, 8'hdf, 1, 0);
      for (int k = 0; k < 600 && !rd_word[5]; k++)
        rd(ADDR_MODE, 8'h00, 0, 0);
      rd(ADDR_MODE, 8'hbf, 1, 0);
      rd(ADDR_RESH, conv_data[11:4], 1, 0);
      hi = rd_word[7:0];
      rd(ADDR_CLKR, {ck[7:4], i[0] ? 4'h0 : conv_data[3:0]}, 1, 0);
      // Software view: high byte joined with the masked nibble
      w = {conv_data[11:4], i[0] ? 4'h0 : conv_data[3:0]};
      chk_word("result word", {20'h0, w}, {20'h0, hi, rd_word[3:0] & 4'hf});
      if (!i[0])
        chk_word("ten bit result", {22'h0, w[11:2]}, {22'h0, hi, rd_word[3:2]});
      chk_bit("irq_req", 1'b1, irq_req);
      chk_word("busy length", n, busy_cnt);
      chk_word("start pulses", i + 1, n_start);
      wr(ADDR_RESH, ~conv_data[11:4]);
      rd(ADDR_RESH, conv_data[11:4], 1, 0);
      wr(ADDR_MODE, 8'h9f);
      rd(ADDR_MODE, 8'h9f, 1, 0);
      wr(ADDR_IRQ, 8'h01);
      chk_bit("irq_req", 1'b0, irq_req);
    end
    chk_word("irq_vector", 32'h8, {24'h0, irq_vector});
    // Power saving: converter switched off when no longer needed
    wr(ADDR_MODE, 8'h00);
    chk_bit("conv_enable", 1'b0, conv_enable);
    finish_test();
  end
endmodule
